// [core/ptc_device.sv]
// Contract
// - byte streams with packets, no channel, latency 0
// - single 32-bit accesses only, never bursts
// - response after each write and no-op
// - unknown codes behave as no-op
// - reads of nonzero size return slave data, not a response
// - packet: code, reserved, size, payload from 8
// - size is payload bytes or bytes to read
// - response: code msb flipped, reserved, count
// - 0x00 writes repeatedly one word address
// - 0x04 writes successive addresses from start
// - 0x10 reads words from one fixed address
// - 0x14 reads size bytes from successive addresses
// - no-op makes no access, still responds
// - one command; sink stalls until finished
// - no data buffer between stream and bus
// - slave wait stalls the sink
// - read held off while source backpressured
// - avoid mid-read backpressure; return received data
// - end of packet ends command and data
// - source sends payload matching size
// - no stream error signalling
// - start of packet mid-command drops it silently
`timescale 1ns/100ps
module ptc_device
   import ptc_pkg::*;
#(
   parameter int AW = ptc_pkg::MM_AW
)(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // packet link
   ptc_if.dev link,
   // memory-mapped master
   output logic [AW-1:0] mm_address_o,
   output logic [ptc_pkg::MM_DW-1:0] mm_writedata_o,
   output logic [3:0] mm_byteenable_o,
   output logic mm_write_o,
   output logic mm_read_o,
   input wire logic [ptc_pkg::MM_DW-1:0] mm_readdata_i,
   input wire logic mm_wait_i
);
   import ptc_pkg::*;

   ptc_state_e state_reg, state_next;
   logic cmd_ready_reg;
   logic [15:0] idx_reg, size_reg, done_reg, lcount_reg;
   logic [7:0] code_reg;
   logic [AW-1:0] addr_reg;
   logic [1:0] lane_reg;
   logic [2:0] wbytes_reg, nb_reg, ld_reg;
   logic eop_seen_reg;
   logic [31:0] rword_reg;
   logic rsp_valid_reg, rsp_sop_reg, rsp_eop_reg;
   logic [7:0] rsp_data_reg;

   // ======================================================
   // decode
   logic rx_fire, tx_fire, mm_done, first, payload, word_full;
   logic is_wr, is_rd, is_inc, hdr_ok, load_ok, more;
   logic [15:0] pos, rem;
   logic [2:0] nb;
   assign rx_fire = link.cmd_valid && cmd_ready_reg;
   assign tx_fire = rsp_valid_reg && link.rsp_ready;
   assign mm_done = (mm_write_o || mm_read_o) && !mm_wait_i;
   // a start marker mid-command restarts decoding
   assign first = link.cmd_sop || (idx_reg == 16'h0000);
   assign pos = first ? 16'h0000 : idx_reg;
   assign is_wr = (code_reg == CODE_WR_FIX) || (code_reg == CODE_WR_INC);
   assign is_rd = (code_reg == CODE_RD_FIX) || (code_reg == CODE_RD_INC);
   assign is_inc = (code_reg == CODE_WR_INC) || (code_reg == CODE_RD_INC);
   assign hdr_ok = pos >= POS_ADDR_LAST;
   assign payload = !first && (idx_reg >= HDR_LEN) && is_wr;
   // one word per access; a short word goes out on end marker
   assign word_full = rx_fire && payload
      && (lane_reg == 2'h3 || link.cmd_eop);
   assign rem = size_reg - lcount_reg;
   assign nb = (rem >= 16'h0004) ? WORD_BYTES : rem[2:0];
   assign load_ok = !rsp_valid_reg || tx_fire;
   assign more = (state_reg == ST_ROUT && ld_reg < nb_reg)
      || (state_reg == ST_RSP && ld_reg < RSP_LEN);

   // ======================================================
   // sequencing
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RX:
            if (word_full)
               state_next = ST_WBUS;
            else if (rx_fire && link.cmd_eop && hdr_ok)
            begin
               if (is_rd && size_reg != 16'h0000)
                  state_next = ST_RREQ;
               else
                  state_next = ST_RSP;
            end
         ST_WBUS:
            if (mm_done)
               state_next = eop_seen_reg ? ST_RSP : ST_RX;
         ST_RREQ:
            if (link.rsp_ready)
               state_next = ST_RBUS;
         ST_RBUS:
            if (mm_done)
               state_next = ST_ROUT;
         ST_ROUT:
            if (tx_fire && ld_reg == nb_reg)
               state_next = (lcount_reg == size_reg) ? ST_RX : ST_RREQ;
         ST_RSP:
            if (tx_fire && ld_reg == RSP_LEN)
               state_next = ST_RX;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= ST_RX;
         cmd_ready_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         // sink is open only while collecting a command
         cmd_ready_reg <= (state_next == ST_RX);
      end
   end

   // ======================================================
   // command context
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         idx_reg <= 16'h0000;
         code_reg <= CODE_NOP;
         size_reg <= 16'h0000;
         addr_reg <= '0;
         lane_reg <= 2'h0;
         wbytes_reg <= 3'h0;
         done_reg <= 16'h0000;
         eop_seen_reg <= 1'b0;
         nb_reg <= 3'h0;
         rword_reg <= 32'h00000000;
      end
      else
      begin
         unique case (state_reg)
            ST_RX:
               if (rx_fire)
               begin
                  if (first)
                  begin
                     code_reg <= link.cmd_data;
                     idx_reg <= 16'h0001;
                     size_reg <= 16'h0000;
                     addr_reg <= '0;
                     lane_reg <= 2'h0;
                     done_reg <= 16'h0000;
                  end
                  else
                  begin
                     if (idx_reg != 16'hFFFF)
                        idx_reg <= idx_reg + 16'h0001;
                     // size and address travel msb first
                     if (idx_reg == POS_SIZE_HI)
                        size_reg[15:8] <= link.cmd_data;
                     if (idx_reg == POS_SIZE_LO)
                        size_reg[7:0] <= link.cmd_data;
                     if (idx_reg >= POS_ADDR_FIRST
                        && idx_reg <= POS_ADDR_LAST)
                        addr_reg <= {addr_reg[AW-9:0],
                           link.cmd_data};
                  end
                  if (payload)
                  begin
                     lane_reg <= lane_reg + 2'h1;
                     wbytes_reg <= {1'b0, lane_reg} + 3'h1;
                  end
                  eop_seen_reg <= link.cmd_eop;
                  // short packets are dropped with no answer
                  if (link.cmd_eop)
                     idx_reg <= 16'h0000;
               end
            ST_WBUS:
               if (mm_done)
               begin
                  done_reg <= done_reg + {13'h0000, wbytes_reg};
                  lane_reg <= 2'h0;
                  if (is_inc)
                     addr_reg <= addr_reg + AW'(4);
               end
            ST_RBUS:
               if (mm_done)
               begin
                  rword_reg <= mm_readdata_i;
                  nb_reg <= nb;
               end
            ST_ROUT:
               if (state_next == ST_RREQ && is_inc)
                  addr_reg <= addr_reg + AW'(4);
            default:
               ;
         endcase
      end
   end

   // ======================================================
   // master port
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mm_address_o <= '0;
         mm_writedata_o <= 32'h00000000;
         mm_byteenable_o <= 4'h0;
         mm_write_o <= 1'b0;
         mm_read_o <= 1'b0;
      end
      else
      begin
         if (state_reg == ST_RX && rx_fire && payload)
         begin
            mm_writedata_o[8*lane_reg +: 8] <= link.cmd_data;
            mm_byteenable_o[lane_reg] <= 1'b1;
         end
         if (state_reg == ST_RX && word_full)
         begin
            // fixed-address writes keep addr_reg as is
            mm_address_o <= {addr_reg[AW-1:2], 2'b00};
            mm_write_o <= 1'b1;
         end
         if (state_reg == ST_RREQ && link.rsp_ready)
         begin
            mm_address_o <= {addr_reg[AW-1:2], 2'b00};
            mm_byteenable_o <= 4'hF;
            mm_read_o <= 1'b1;
         end
         if (mm_done)
         begin
            mm_write_o <= 1'b0;
            mm_read_o <= 1'b0;
            {mm_writedata_o, mm_byteenable_o} <= 36'h000000000;
         end
      end
   end

   // ======================================================
   // response source
   logic [7:0] rsp_byte;
   always_comb
   begin
      rsp_byte = 8'h00;
      if (state_reg == ST_ROUT)
         rsp_byte = rword_reg[8*ld_reg[1:0] +: 8];
      else
         unique case (ld_reg)
            3'h0: rsp_byte = code_reg ^ CODE_MSB;
            3'h3: rsp_byte = done_reg[15:8];
            3'h4: rsp_byte = done_reg[7:0];
            default: rsp_byte = 8'h00;
         endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
         rsp_sop_reg <= 1'b0;
         rsp_eop_reg <= 1'b0;
         ld_reg <= 3'h0;
         lcount_reg <= 16'h0000;
      end
      else
      begin
         // data is held until taken, so no byte is dropped
         if (load_ok)
         begin
            rsp_valid_reg <= more;
            if (more)
            begin
               rsp_data_reg <= rsp_byte;
               ld_reg <= ld_reg + 3'h1;
               if (state_reg == ST_ROUT)
               begin
                  lcount_reg <= lcount_reg + 16'h0001;
                  rsp_sop_reg <= (lcount_reg == 16'h0000);
                  rsp_eop_reg <= (lcount_reg + 16'h0001 == size_reg);
               end
               else
               begin
                  rsp_sop_reg <= (ld_reg == 3'h0);
                  rsp_eop_reg <= (ld_reg == RSP_LEN - 3'h1);
               end
            end
         end
         if (state_reg != ST_ROUT && state_reg != ST_RSP)
            ld_reg <= 3'h0;
         if (state_reg == ST_RX)
            lcount_reg <= 16'h0000;
      end
   end

   // no error lane exists on either stream
   assign link.cmd_ready = cmd_ready_reg;
   assign link.rsp_valid = rsp_valid_reg;
   assign link.rsp_data = rsp_data_reg;
   assign link.rsp_sop = rsp_sop_reg;
   assign link.rsp_eop = rsp_eop_reg;
endmodule : ptc_device

// [core/ptc_pkg.sv]
package ptc_pkg;
   // ======================================================
   // widths and framing
   localparam int SYM_W = 8;
   localparam int MM_DW = 32;
   localparam int MM_AW = 32;
   localparam logic [15:0] POS_SIZE_HI = 16'h0002;
   localparam logic [15:0] POS_SIZE_LO = 16'h0003;
   localparam logic [15:0] POS_ADDR_FIRST = 16'h0004;
   localparam logic [15:0] POS_ADDR_LAST = 16'h0007;
   localparam logic [15:0] HDR_LEN = 16'h0008;
   localparam logic [2:0] RSP_LEN = 3'h5;
   localparam logic [2:0] WORD_BYTES = 3'h4;
   // ======================================================
   // command codes
   localparam logic [7:0] CODE_WR_FIX = 8'h00;
   localparam logic [7:0] CODE_WR_INC = 8'h04;
   localparam logic [7:0] CODE_RD_FIX = 8'h10;
   localparam logic [7:0] CODE_RD_INC = 8'h14;
   localparam logic [7:0] CODE_NOP = 8'h7F;
   localparam logic [7:0] CODE_MSB = 8'h80;
   // ======================================================
   // states
   typedef enum logic [2:0] {
      ST_RX, ST_WBUS, ST_RREQ, ST_RBUS, ST_ROUT, ST_RSP
   } ptc_state_e;
   typedef enum logic [1:0] {HS_IDLE, HS_HDR, HS_PAY} ptc_hstate_e;
endpackage : ptc_pkg

// [core/ptc_if.sv]
`timescale 1ns/100ps
interface ptc_if;
   // command stream, packet source toward converter
   logic cmd_valid;
   logic [7:0] cmd_data;
   logic cmd_sop;
   logic cmd_eop;
   logic cmd_ready;
   // response stream, converter toward packet consumer
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_sop;
   logic rsp_eop;
   logic rsp_ready;
   modport dev (
      input cmd_valid, cmd_data, cmd_sop, cmd_eop, rsp_ready,
      output cmd_ready, rsp_valid, rsp_data, rsp_sop, rsp_eop
   );
   modport host (
      output cmd_valid, cmd_data, cmd_sop, cmd_eop, rsp_ready,
      input cmd_ready, rsp_valid, rsp_data, rsp_sop, rsp_eop
   );
endinterface : ptc_if

// [core/ptc_host.sv]
`timescale 1ns/100ps
module ptc_host
   import ptc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // packet link
   ptc_if.host link,
   // command request
   input wire logic cmd_start_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_size_i,
   input wire logic [ptc_pkg::MM_AW-1:0] cmd_addr_i,
   output logic busy_o,
   // write payload
   input wire logic pay_valid_i,
   input wire logic [7:0] pay_data_i,
   output logic pay_ready_o,
   // received bytes
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_sop_o,
   output logic rx_eop_o
);
   import ptc_pkg::*;

   ptc_hstate_e st_reg;
   logic [7:0] code_reg;
   logic [15:0] size_reg, pcnt_reg;
   logic [31:0] addr_reg;
   logic [3:0] hcnt_reg;
   logic cvalid_reg, csop_reg, ceop_reg, rsp_ready_reg;
   logic [7:0] cdata_reg;

   logic cfire, load_ok, has_pay;
   logic [7:0] hdr_byte;
   assign cfire = cvalid_reg && link.cmd_ready;
   assign load_ok = !cvalid_reg || cfire;
   assign has_pay = (code_reg == CODE_WR_FIX || code_reg == CODE_WR_INC)
      && size_reg != 16'h0000;

   // ======================================================
   // header layout, fields msb first
   always_comb
   begin
      unique case (hcnt_reg[2:0])
         3'h0: hdr_byte = code_reg;
         3'h2: hdr_byte = size_reg[15:8];
         3'h3: hdr_byte = size_reg[7:0];
         3'h4: hdr_byte = addr_reg[31:24];
         3'h5: hdr_byte = addr_reg[23:16];
         3'h6: hdr_byte = addr_reg[15:8];
         3'h7: hdr_byte = addr_reg[7:0];
         default: hdr_byte = 8'h00;
      endcase
   end

   // ======================================================
   // command packet source
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_reg <= HS_IDLE;
         code_reg <= CODE_NOP;
         size_reg <= 16'h0000;
         addr_reg <= 32'h00000000;
         hcnt_reg <= 4'h0;
         pcnt_reg <= 16'h0000;
         busy_o <= 1'b0;
         pay_ready_o <= 1'b0;
         cvalid_reg <= 1'b0;
         cdata_reg <= 8'h00;
         csop_reg <= 1'b0;
         ceop_reg <= 1'b0;
      end
      else
      begin
         if (cfire)
            cvalid_reg <= 1'b0;
         unique case (st_reg)
            HS_IDLE:
               if (cmd_start_i)
               begin
                  code_reg <= cmd_code_i;
                  size_reg <= cmd_size_i;
                  addr_reg <= cmd_addr_i;
                  hcnt_reg <= 4'h0;
                  pcnt_reg <= 16'h0000;
                  busy_o <= 1'b1;
                  st_reg <= HS_HDR;
               end
            HS_HDR:
               if (load_ok)
               begin
                  if (hcnt_reg < HDR_LEN[3:0])
                  begin
                     cvalid_reg <= 1'b1;
                     cdata_reg <= hdr_byte;
                     csop_reg <= (hcnt_reg == 4'h0);
                     ceop_reg <= (hcnt_reg == 4'h7) && !has_pay;
                     hcnt_reg <= hcnt_reg + 4'h1;
                  end
                  else if (has_pay)
                     st_reg <= HS_PAY;
                  else
                  begin
                     busy_o <= 1'b0;
                     st_reg <= HS_IDLE;
                  end
               end
            HS_PAY:
               // one payload byte in flight; only size bytes are sent
               if (pay_ready_o)
               begin
                  if (pay_valid_i)
                  begin
                     pay_ready_o <= 1'b0;
                     cvalid_reg <= 1'b1;
                     cdata_reg <= pay_data_i;
                     csop_reg <= 1'b0;
                     ceop_reg <= (pcnt_reg + 16'h0001 == size_reg);
                     pcnt_reg <= pcnt_reg + 16'h0001;
                  end
               end
               else if (load_ok)
               begin
                  if (pcnt_reg == size_reg)
                  begin
                     busy_o <= 1'b0;
                     st_reg <= HS_IDLE;
                  end
                  else
                     pay_ready_o <= 1'b1;
               end
            default:
               st_reg <= HS_IDLE;
         endcase
      end
   end

   // ======================================================
   // response sink, never backpressured to avoid read loss
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rsp_ready_reg <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 8'h00;
         rx_sop_o <= 1'b0;
         rx_eop_o <= 1'b0;
      end
      else
      begin
         rsp_ready_reg <= 1'b1;
         rx_valid_o <= link.rsp_valid && rsp_ready_reg;
         if (link.rsp_valid && rsp_ready_reg)
         begin
            rx_data_o <= link.rsp_data;
            rx_sop_o <= link.rsp_sop;
            rx_eop_o <= link.rsp_eop;
         end
      end
   end

   assign link.cmd_valid = cvalid_reg;
   assign link.cmd_data = cdata_reg;
   assign link.cmd_sop = csop_reg;
   assign link.cmd_eop = ceop_reg;
   assign link.rsp_ready = rsp_ready_reg;
endmodule : ptc_host

// [verification/ptc_checker.sv]
`timescale 1ns/100ps
module ptc_checker (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // packet link
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_eop,
   input wire logic rsp_ready,
   // master port
   input wire logic [31:0] mm_address_o,
   input wire logic [31:0] mm_writedata_o,
   input wire logic [3:0] mm_byteenable_o,
   input wire logic mm_write_o,
   input wire logic mm_read_o,
   input wire logic mm_wait_i
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // ======================================================
   // sequences
   sequence acc_stall;
      (mm_write_o || mm_read_o) && mm_wait_i;
   endsequence
   sequence rsp_last;
      rsp_valid && rsp_ready && rsp_eop;
   endsequence
   // ======================================================
   // properties
   a_sink_held: assert property (
      (mm_write_o || mm_read_o || rsp_valid) |-> !cmd_ready)
      else $error("sink ready during access or reply");
   a_access_stands: assert property (
      acc_stall |=> $stable({mm_write_o, mm_read_o, mm_address_o})
         && $stable(mm_byteenable_o))
      else $error("access changed while stalled");
   a_wdata_stands: assert property (
      mm_write_o && mm_wait_i |=> $stable(mm_writedata_o))
      else $error("write data changed while stalled");
   a_one_strobe: assert property (
      !(mm_write_o && mm_read_o))
      else $error("read and write together");
   a_read_lanes: assert property (
      mm_read_o |-> mm_byteenable_o == 4'hF && mm_address_o[1:0] == 2'h0)
      else $error("read not a full aligned word");
   a_write_lanes: assert property (
      mm_write_o |-> mm_byteenable_o != 4'h0 && mm_address_o[1:0] == 2'h0)
      else $error("write without lanes or unaligned");
   a_read_backoff: assert property (
      $rose(mm_read_o) |-> $past(rsp_ready))
      else $error("read raised under backpressure");
   a_reply_hold: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("reply byte dropped");
   a_cmd_hold: assert property (
      cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
      else $error("command byte withdrawn");
   a_ready_return: assert property (
      rsp_last |-> ##[1:4] cmd_ready)
      else $error("sink not ready after reply");
endmodule : ptc_checker

// [verification/packets_to_transactions_converter_tb.sv]
`timescale 1ns/100ps
module packets_to_transactions_converter_tb;
   import ptc_pkg::*;
   typedef logic [68:0] ptc_item_t;
   localparam logic [7:0] CODES [9] = '{8'h7F, 8'h01, 8'hFE, 8'h04, 8'h00,
      8'h14, 8'h10, 8'h14, 8'h04};
   localparam int SIZES [9] = '{0, 3, 0, 7, 6, 6, 8, 0, 9};
   logic sys_clk_i, sys_rst_i, cmd_start_i, pay_valid_i, busy_o, pay_ready_o;
   logic [7:0] cmd_code_i, pay_data_i, rx_data_o;
   logic [15:0] cmd_size_i;
   logic [31:0] cmd_addr_i, mm_address_o, mm_writedata_o, mm_readdata_i, rnd;
   logic rx_valid_o, rx_sop_o, rx_eop_o, mm_write_o, mm_read_o, mm_wait_i;
   logic [3:0] mm_byteenable_o;
   logic wait_en, wr2_o, rd2_o;
   int mismatches, comparisons, wr2;
   // 0 access, 1 host bytes, 2 reply wire, 3 command wire, 4 fault end
   ptc_item_t sq [5][$];
   ptc_item_t eq [5][$];
   logic [7:0] pay_q [$];
   ptc_if lnk();
   ptc_if lnk2();
   ptc_host i_ptc_host (.sys_clk_i, .sys_rst_i, .link(lnk), .cmd_start_i,
      .cmd_code_i, .cmd_size_i, .cmd_addr_i, .busy_o, .pay_valid_i,
      .pay_data_i, .pay_ready_o, .rx_valid_o, .rx_data_o, .rx_sop_o, .rx_eop_o);
   ptc_device i_ptc_device (.sys_clk_i, .sys_rst_i, .link(lnk), .mm_address_o,
      .mm_writedata_o, .mm_byteenable_o, .mm_write_o, .mm_read_o,
      .mm_readdata_i, .mm_wait_i);
   // second device fed by hand-made malformed packets
   ptc_device i_ptc_device_b (.sys_clk_i, .sys_rst_i, .link(lnk2),
      .mm_address_o(), .mm_writedata_o(), .mm_byteenable_o(),
      .mm_write_o(wr2_o), .mm_read_o(rd2_o), .mm_readdata_i(32'h0),
      .mm_wait_i(1'b0));
   ptc_checker i_ptc_checker (.sys_clk_i, .sys_rst_i,
      .cmd_valid(lnk.cmd_valid), .cmd_data(lnk.cmd_data),
      .cmd_ready(lnk.cmd_ready), .rsp_valid(lnk.rsp_valid),
      .rsp_data(lnk.rsp_data), .rsp_eop(lnk.rsp_eop),
      .rsp_ready(lnk.rsp_ready), .mm_address_o, .mm_writedata_o,
      .mm_byteenable_o, .mm_write_o, .mm_read_o, .mm_wait_i);
   // slave data is a pure function of the address so stalls cannot skew it
   assign mm_readdata_i = mm_address_o ^ 32'h5AC3E10F;
   // ======================================================
   // clock, slave stalls, payload feed and monitors
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   always @(posedge sys_clk_i)
   begin
      rnd <= sys_rst_i ? 32'h935C : lfsr_next(rnd);
      mm_wait_i <= wait_en && (rnd[1:0] == 2'h0);
      if ((mm_write_o || mm_read_o) && mm_wait_i === 1'b0)
         sq[0].push_back({mm_write_o, mm_address_o,
            mm_write_o ? mm_writedata_o : 32'h0, mm_byteenable_o});
      if (rx_valid_o === 1'b1)
         sq[1].push_back({rx_sop_o, rx_eop_o, rx_data_o});
      if (lnk.rsp_valid && lnk.rsp_ready)
         sq[2].push_back({lnk.rsp_sop, lnk.rsp_eop, lnk.rsp_data});
      if (lnk.cmd_valid && lnk.cmd_ready)
         sq[3].push_back({lnk.cmd_sop, lnk.cmd_eop, lnk.cmd_data});
      if (lnk2.rsp_valid && lnk2.rsp_ready)
         sq[4].push_back({lnk2.rsp_sop, lnk2.rsp_eop, lnk2.rsp_data});
      if (wr2_o || rd2_o)
         wr2++;
      if (pay_valid_i && pay_ready_o)
         void'(pay_q.pop_front());
      pay_valid_i <= pay_q.size() > 0;
      pay_data_i <= pay_q.size() > 0 ? pay_q[0] : 8'h00;
   end
   // ======================================================
   // checking
   task automatic check(input string nm, input ptc_item_t got,
      input ptc_item_t exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic clr();
      for (int k = 0; k < 5; k++)
      begin
         sq[k].delete();
         eq[k].delete();
      end
      wr2 = 0;
   endtask : clr
   task automatic cmp_all(input string nm);
      for (int k = 0; k < 5; k++)
      begin
         check($sformatf("%s count %0d", nm, k), sq[k].size(), eq[k].size());
         for (int i = 0; i < sq[k].size() && i < eq[k].size(); i++)
            check($sformatf("%s q%0d[%0d]", nm, k, i), sq[k][i], eq[k][i]);
      end
      $display("test %s done", nm);
   endtask : cmp_all
   task automatic exp_rsp(input logic s, input logic e, input logic [7:0] d);
      eq[1].push_back({s, e, d});
      eq[2].push_back({s, e, d});
   endtask : exp_rsp
   // ======================================================
   // behavioural model and command driver
   task automatic run_cmd(input logic [7:0] c, input int sz,
      input logic [31:0] a);
      logic [31:0] s, wa, wd, w;
      logic [63:0] hdr;
      logic [39:0] r;
      logic [3:0] be;
      logic wr, rd;
      int n;
      clr();
      s = rnd ^ a;
      wa = a;
      wd = 32'h0;
      be = 4'h0;
      wr = (c == CODE_WR_FIX) || (c == CODE_WR_INC);
      rd = (c == CODE_RD_FIX) || (c == CODE_RD_INC);
      hdr = {c, 8'h00, sz[15:0], a};
      r = {c ^ CODE_MSB, 16'h0000, wr ? sz[15:0] : 16'h0000};
      for (int i = 0; i < 8; i++)
         eq[3].push_back({i == 0, !wr && i == 7, hdr[63 - 8 * i -: 8]});
      for (int i = 0; i < sz && wr; i++)
      begin
         s = lfsr_next(s);
         pay_q.push_back(s[7:0]);
         eq[3].push_back({1'b0, i == sz - 1, s[7:0]});
         wd[8 * (i % 4) +: 8] = s[7:0];
         be[i % 4] = 1'b1;
         if (i % 4 == 3 || i == sz - 1)
         begin
            eq[0].push_back({1'b1, wa, wd, be});
            wa = wa + (c[2] ? 32'h4 : 32'h0);
            wd = 32'h0;
            be = 4'h0;
         end
      end
      for (int i = 0; i < sz && rd; i++)
      begin
         w = wa ^ 32'h5AC3E10F;
         if (i % 4 == 0)
            eq[0].push_back({1'b0, wa, 32'h0, 4'hF});
         exp_rsp(i == 0, i == sz - 1, w[8 * (i % 4) +: 8]);
         if (i % 4 == 3)
            wa = wa + (c[2] ? 32'h4 : 32'h0);
      end
      for (int i = 0; i < 5 && (!rd || sz == 0); i++)
         exp_rsp(i == 0, i == 4, r[39 - 8 * i -: 8]);
      @(posedge sys_clk_i);
      cmd_start_i <= 1'b1;
      cmd_code_i <= c;
      cmd_size_i <= sz[15:0];
      cmd_addr_i <= a;
      @(posedge sys_clk_i);
      cmd_start_i <= 1'b0;
      n = 0;
      while (sq[1].size() < eq[1].size() && n < 3000)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (4) @(posedge sys_clk_i);
      check("sink idle", lnk.cmd_ready, 1'b1);
      cmp_all($sformatf("cmd %h size %0d", c, sz));
   endtask : run_cmd
   // sends nb bytes from the top of p; valid stays up between beats
   task automatic pkt2(input logic [95:0] p, input int nb, input logic e);
      int n;
      for (int i = 0; i < nb; i++)
      begin
         lnk2.cmd_valid <= 1'b1;
         lnk2.cmd_data <= p[95 - 8 * i -: 8];
         lnk2.cmd_sop <= i == 0;
         lnk2.cmd_eop <= e && i == nb - 1;
         n = 0;
         do
         begin
            @(posedge sys_clk_i);
            n++;
         end
         while (lnk2.cmd_ready !== 1'b1 && n < 100);
      end
      if (e)
         lnk2.cmd_valid <= 1'b0;
   endtask : pkt2
   task automatic fault_case(input string nm, input logic [95:0] p1,
      input int n1, input logic [95:0] p2, input int n2,
      input logic [39:0] r, input int wn);
      clr();
      for (int i = 0; i < 5; i++)
         eq[4].push_back({i == 0, i == 4, r[39 - 8 * i -: 8]});
      pkt2(p1, n1, n2 == 0);
      if (n2 > 0)
         pkt2(p2, n2, 1'b1);
      repeat (40) @(posedge sys_clk_i);
      check({nm, " writes"}, wr2, wn);
      cmp_all(nm);
   endtask : fault_case
   // ======================================================
   // run control
   task finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial
   begin
      #600000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      {sys_rst_i, cmd_code_i, cmd_size_i, cmd_addr_i} = '1;
      {cmd_start_i, wait_en} = '0;
      {lnk2.cmd_valid, lnk2.cmd_data, lnk2.cmd_sop, lnk2.cmd_eop} = '0;
      lnk2.rsp_ready = 1'b1;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      for (int p = 0; p < 2; p++)
      begin
         wait_en <= p[0];
         for (int t = 0; t < 9; t++)
            run_cmd(CODES[t], SIZES[t], (32'(t) << 8) | (32'(p) << 12));
      end
      fault_case("restart", {CODE_WR_INC, 24'h000004, 32'h00000100, 32'h0},
         8, {CODE_NOP, 88'h0}, 8, {8'hFF, 32'h0}, 0);
      fault_case("short", {CODE_WR_INC, 24'h000008, 32'h00000040,
         32'hAABBCCDD}, 12, 96'h0, 0, {8'h84, 24'h0, 8'h04}, 1);
      finish_test();
   end
endmodule : packets_to_transactions_converter_tb
